// file: include/scs_consts.svh
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH
// register word offsets (byte addresses = index * 4)
`define SCS_IDX_SLEW        16'h1C16
`define SCS_IDX_PULL        16'h1C18
`define SCS_IDX_DEBUG_CLOCK_OUTPUT_PIN_CFG  16'h1C20
`define SCS_IDX_CPU_ST3     16'h1C21
`define SCS_IDX_USB_PWR     16'h1C22
`define SCS_IDX_STATUS      16'h1C23
// field positions
`define SCS_CFG_SRC_LSB     0
`define SCS_CFG_SRC_W       2
`define SCS_ST3_OFF_BIT     0
`define SCS_PULL_EXTERNAL_CLOCK_INPUT_PIN_BIT  0
`define SCS_SLEW_DEBUG_CLOCK_OUTPUT_PIN_BIT 0
`define SCS_USB_OSC_BIT     0
`define SCS_USB_LDO_BIT     1
// reset values
`define SCS_RST_SLEW        16'h0000
`define SCS_RST_PULL        16'h0001
`define SCS_RST_CFG         16'h0000
`define SCS_RST_ST3         16'h0000
`define SCS_RST_USB         16'h0000
`endif

// file: include/scs_pkg.sv
package scs_pkg;
  typedef enum logic [1:0] {
    SCS_SRC_SYS,
    SCS_SRC_PLL_IN,
    SCS_SRC_PLL_OUT,
    SCS_SRC_REF
  } scs_src_t;
  typedef enum logic [1:0] {
    SCS_BUS_IDLE,
    SCS_BUS_ACK
  } scs_bus_state_t;
endpackage : scs_pkg

// file: design/scs_clk_mux.sv
`timescale 1ns/10ps
`default_nettype none
// registered four-way clock tap selector
module scs_clk_mux (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_sel,
  input  wire logic [3:0] i_taps,
  output var  logic       o_tap
);
  wire logic picked;
  assign picked = i_taps[i_sel];
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_tap <= 1'b0;
    else       o_tap <= picked;
  end
endmodule : scs_clk_mux
`default_nettype wire

// file: design/scs_clock_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "scs_consts.svh"
module scs_clock_ctrl (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_clk_sel_strap,
  input  wire logic        i_usb_osc_clk,
  input  wire logic        i_ext_clk_in,
  input  wire logic [3:0]  i_gen_taps,
  input  wire logic [17:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  output var  logic        o_sys_clk_src,
  output var  logic        o_use_ext_clk,
  output var  logic        o_usb_osc_en,
  output var  logic        o_usb_regulator_enable,
  output var  logic        o_debug_clock_output_pin,
  output var  logic        o_debug_clock_oe,
  output var  logic        o_debug_clock_pulldown_en,
  output var  logic        o_debug_clock_fast_slew,
  output var  logic        o_ext_clk_pulldown_en
);
  scs_pkg::scs_bus_state_t st_r;
  logic        strap_r;
  logic        strap_live_r;
  logic [15:0] slew_r;
  logic [15:0] pull_r;
  logic [15:0] cfg_r;
  logic [15:0] st3_r;
  logic [15:0] usb_r;
  logic [1:0]  src_sel;
  logic        tap;

  // word index from byte address
  wire logic [15:0] idx;
  wire logic        req;
  wire logic        wr_go;
  wire logic        hit_slew;
  wire logic        hit_pull;
  wire logic        hit_cfg;
  wire logic        hit_st3;
  wire logic        hit_usb;
  wire logic        hit_stat;
  wire logic [15:0] rd_word;
  wire logic [15:0] usb_eff;
  wire logic        drv_off;
  wire logic        sys_src;
  wire logic [15:0] slew_nxt;
  wire logic [15:0] pull_nxt;
  wire logic [15:0] cfg_nxt;
  wire logic [15:0] st3_nxt;
  wire logic [15:0] usb_nxt;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  assign idx      = avs_address[17:2];
  assign req      = avs_read | avs_write;
  // write lands on the edge at which the master sees waitrequest low
  assign wr_go    = avs_write & (st_r == scs_pkg::SCS_BUS_ACK);
  assign hit_slew = (idx == `SCS_IDX_SLEW);
  assign hit_pull = (idx == `SCS_IDX_PULL);
  assign hit_cfg  = (idx == `SCS_IDX_DEBUG_CLOCK_OUTPUT_PIN_CFG);
  assign hit_st3  = (idx == `SCS_IDX_CPU_ST3);
  assign hit_usb  = (idx == `SCS_IDX_USB_PWR);
  assign hit_stat = (idx == `SCS_IDX_STATUS);
  // strap low forces usb oscillator and regulator on
  assign usb_eff  = strap_r ? usb_r
                  : (usb_r | (16'h0001 << `SCS_USB_OSC_BIT) | (16'h0001 << `SCS_USB_LDO_BIT));
  assign rd_word  = hit_slew ? slew_r :
                    hit_pull ? pull_r :
                    hit_cfg  ? cfg_r  :
                    hit_st3  ? st3_r  :
                    hit_usb  ? usb_eff :
                    hit_stat ? {15'h0000, strap_r} : 16'h0000;
  assign drv_off  = st3_r[`SCS_ST3_OFF_BIT];
  // strap high selects external input, else usb oscillator
  assign sys_src  = strap_r ? i_ext_clk_in : i_usb_osc_clk;
  assign src_sel  = cfg_r[`SCS_CFG_SRC_LSB +: `SCS_CFG_SRC_W];

  // selection of generator tap for the output pin
  scs_clk_mux u_mux (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_sel  (src_sel),
    .i_taps (i_gen_taps),
    .o_tap  (tap)
  );

  // strap sampled once, on the first edge after reset release, frozen from then on
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) strap_live_r <= 1'b1;
    else       strap_live_r <= 1'b0;
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) strap_r <= 1'b0;
    else if (strap_live_r) strap_r <= i_clk_sel_strap;
  end

  // one wait cycle per access: request seen in idle, answered next cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) st_r <= scs_pkg::SCS_BUS_IDLE;
    else if (st_r == scs_pkg::SCS_BUS_IDLE && req) st_r <= scs_pkg::SCS_BUS_ACK;
    else st_r <= scs_pkg::SCS_BUS_IDLE;
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) avs_waitrequest <= 1'b1;
    else       avs_waitrequest <= ~(st_r == scs_pkg::SCS_BUS_IDLE && req);
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) avs_readdata <= 32'h00000000;
    else       avs_readdata <= {16'h0000, rd_word};
  end

  // next values: a register holds unless a completed write hits it
  assign slew_nxt = (wr_go && hit_slew) ? merge16(slew_r, avs_writedata, avs_byteenable)
                                        : slew_r;
  assign pull_nxt = (wr_go && hit_pull) ? merge16(pull_r, avs_writedata, avs_byteenable)
                                        : pull_r;
  assign cfg_nxt  = (wr_go && hit_cfg)  ? merge16(cfg_r, avs_writedata, avs_byteenable)
                                        : cfg_r;
  assign st3_nxt  = (wr_go && hit_st3)  ? merge16(st3_r, avs_writedata, avs_byteenable)
                                        : st3_r;
  // usb bits stay writable; strap low overrides them on the way out
  assign usb_nxt  = (wr_go && hit_usb)  ? merge16(usb_r, avs_writedata, avs_byteenable)
                                        : usb_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) slew_r <= `SCS_RST_SLEW;
    else       slew_r <= slew_nxt;
  end

  // pulldown inhibited out of reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) pull_r <= `SCS_RST_PULL;
    else       pull_r <= pull_nxt;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) cfg_r <= `SCS_RST_CFG;
    else       cfg_r <= cfg_nxt;
  end

  // driver on after reset until boot code sets the off bit
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) st3_r <= `SCS_RST_ST3;
    else       st3_r <= st3_nxt;
  end

  // off unless strap forces
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) usb_r <= `SCS_RST_USB;
    else       usb_r <= usb_nxt;
  end

  // one-cycle lag on the source sample; only which clock runs matters
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_sys_clk_src <= 1'b0;
    else       o_sys_clk_src <= sys_src;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_use_ext_clk <= 1'b0;
    else       o_use_ext_clk <= strap_r;
  end

  // usb enables read 1 during reset since the strap is not latched yet
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_usb_osc_en <= 1'b1;
    else       o_usb_osc_en <= usb_eff[`SCS_USB_OSC_BIT];
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_usb_regulator_enable <= 1'b1;
    else       o_usb_regulator_enable <= usb_eff[`SCS_USB_LDO_BIT];
  end

  // pin held low while tristated so the pad never sees a stale tap
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_debug_clock_output_pin <= 1'b0;
    else       o_debug_clock_output_pin <= tap & ~drv_off;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_debug_clock_oe <= 1'b1;
    else       o_debug_clock_oe <= ~drv_off;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_debug_clock_pulldown_en <= 1'b0;
    else       o_debug_clock_pulldown_en <= drv_off;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_debug_clock_fast_slew <= 1'b0;
    else       o_debug_clock_fast_slew <= slew_r[`SCS_SLEW_DEBUG_CLOCK_OUTPUT_PIN_BIT];
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_ext_clk_pulldown_en <= 1'b0;
    else       o_ext_clk_pulldown_en <= ~pull_r[`SCS_PULL_EXTERNAL_CLOCK_INPUT_PIN_BIT];
  end
endmodule : scs_clock_ctrl
`default_nettype wire

// file: verification/scs_checker.sv
`timescale 1ns/10ps
`default_nettype none
module scs_checker (
  input wire logic i_clk, i_rst, i_usb_osc_clk, i_ext_clk_in, avs_write,
  input wire logic o_sys_clk_src, o_use_ext_clk, o_usb_osc_en, o_usb_regulator_enable,
  input wire logic o_debug_clock_oe, o_debug_clock_output_pin, o_debug_clock_pulldown_en,
  input wire logic o_debug_clock_fast_slew, o_ext_clk_pulldown_en
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_run; !$past(i_rst, 3) && !$past(i_rst, 2) && !$past(i_rst); endsequence
  // outputs trail a taken write by one or two edges
  sequence s_wr; $past(avs_write) || $past(avs_write, 2); endsequence
  property p_src; s_run |-> o_sys_clk_src ==
    (o_use_ext_clk ? $past(i_ext_clk_in) : $past(i_usb_osc_clk)); endproperty
  a_src: assert property (p_src) else $error("source");
  property p_usb; s_run ##0 !o_use_ext_clk |-> o_usb_osc_en && o_usb_regulator_enable;
  endproperty
  a_usb: assert property (p_usb) else $error("usb");
  property p_keep; s_run |-> $stable(o_use_ext_clk); endproperty
  a_keep: assert property (p_keep) else $error("strap");
  property p_pd; o_debug_clock_pulldown_en != o_debug_clock_oe; endproperty
  a_pd: assert property (p_pd) else $error("pulldown");
  property p_off; !o_debug_clock_oe [*3] |-> !o_debug_clock_output_pin; endproperty
  a_off: assert property (p_off) else $error("pin");
  property p_oe; $fell(o_debug_clock_oe) |-> s_wr; endproperty
  a_oe: assert property (p_oe) else $error("driver");
  property p_ipd; $changed(o_ext_clk_pulldown_en) |-> s_wr; endproperty
  a_ipd: assert property (p_ipd) else $error("inpull");
  property p_slew; $changed(o_debug_clock_fast_slew) |-> s_wr; endproperty
  a_slew: assert property (p_slew) else $error("slew");
endmodule : scs_checker
bind scs_clock_ctrl scs_checker scs_checker_i (.*);
`default_nettype wire

// file: verification/scs_board.sv
`timescale 1ns/10ps
`default_nettype none
module scs_board (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_mode,
  output var  logic o_strap,
  output wire logic o_ext_clk
);
  logic [1:0] div_r = 2'h0;
  initial o_strap = 1'b0;
  // strap only moves while the device is held in reset
  always @(posedge i_clk) if (i_rst) o_strap <= i_mode;
  always @(posedge i_clk) div_r <= div_r + 2'h1;
  assign o_ext_clk = o_strap & div_r[1];
endmodule : scs_board
`default_nettype wire

// file: verification/scs_clock_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "scs_consts.svh"
module scs_clock_ctrl_tb;
  logic i_clk = 1'b0, i_rst = 1'b1, mode = 1'b0, i_usb_osc_clk = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] i_gen_taps = 4'h0;
  logic [17:0] avs_address = 18'h0;
  logic [31:0] avs_writedata = 32'h0, got;
  wire logic [31:0] avs_readdata;
  wire logic i_clk_sel_strap, i_ext_clk_in, avs_waitrequest, o_sys_clk_src, o_use_ext_clk;
  wire logic o_usb_osc_en, o_usb_regulator_enable, o_debug_clock_output_pin, o_debug_clock_oe;
  wire logic o_debug_clock_pulldown_en, o_debug_clock_fast_slew, o_ext_clk_pulldown_en;
  wire logic [7:0] outs = {o_use_ext_clk, o_usb_regulator_enable, o_usb_osc_en,
    o_debug_clock_oe, o_debug_clock_pulldown_en, o_ext_clk_pulldown_en,
    o_debug_clock_fast_slew, o_debug_clock_output_pin};
  int err_count = 0, total_checks = 0, s;
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) i_usb_osc_clk <= ~i_usb_osc_clk;
  scs_board scs_board_i (.i_clk, .i_rst, .i_mode(mode), .o_strap(i_clk_sel_strap),
    .o_ext_clk(i_ext_clk_in));
  scs_clock_ctrl scs_clock_ctrl_i (.*, .avs_byteenable(4'hF));
  task automatic report_and_stop;
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    avs_address <= {i, 2'h0};
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    // waitrequest and read data both taken at the rising edge
    do begin
      @(posedge i_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 9);
    if (avs_waitrequest !== 1'b0) begin
      chk("waitrequest", 32'h0, 32'h1);
      report_and_stop();
    end
    got = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : acc
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (3) @(negedge i_clk);
    chk("outs", 32'h70, outs);
    acc(1'b0, `SCS_IDX_PULL, 32'h0);
    chk("pull", 32'h1, got);
    acc(1'b1, `SCS_IDX_USB_PWR, 32'h0);
    acc(1'b1, `SCS_IDX_PULL, 32'h0);
    acc(1'b1, `SCS_IDX_SLEW, 32'h1);
    acc(1'b0, `SCS_IDX_USB_PWR, 32'h0);
    chk("usb", 32'h3, got);
    chk("outs", 32'h76, outs);
    // inverted taps too, so a stuck pin cannot pass
    for (s = 0; s < 8; s++) begin
      acc(1'b1, `SCS_IDX_DEBUG_CLOCK_OUTPUT_PIN_CFG, {30'h0, s[2:1]});
      i_gen_taps <= s[0] ? 4'h1 << s[2:1] : ~(4'h1 << s[2:1]);
      repeat (4) @(negedge i_clk);
      chk("pin", s[0], outs[0]);
    end
    acc(1'b1, `SCS_IDX_CPU_ST3, 32'h1);
    repeat (4) @(negedge i_clk);
    chk("outs", 32'h6E, outs);
    acc(1'b1, `SCS_IDX_CPU_ST3, 32'h0);
    repeat (4) @(negedge i_clk);
    chk("outs", 32'h77, outs);
    acc(1'b0, 16'h1C30, 32'h0);
    chk("unmapped", 32'h0, got);
    @(posedge i_clk);
    i_rst <= 1'b1;
    mode <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (3) @(negedge i_clk);
    chk("outs", 32'h90, outs);
    acc(1'b0, `SCS_IDX_STATUS, 32'h0);
    chk("status", 32'h1, got);
    acc(1'b1, `SCS_IDX_USB_PWR, 32'h3);
    repeat (3) @(negedge i_clk);
    chk("outs", 32'hF0, outs);
    report_and_stop();
  end
endmodule : scs_clock_ctrl_tb
`default_nettype wire
